// file: hw/fpsc_pkg.sv
// package: offsets, field layout, reset values and carrier types of the fp status/control block
package fpsc_pkg;

  // apb word offsets of the 64-bit register, low word then high word
  localparam logic [11:0] ADDR_LO = 12'h000;
  localparam logic [11:0] ADDR_HI = 12'h004;

  // global layout of the 64-bit register
  localparam int TRAPS_LO  = 0;   // trap-disable bits 5:0
  localparam int TRAPS_W   = 6;
  localparam int SET_W     = 13;  // width of one status set
  localparam int SET_NUM   = 4;
  localparam int SET0_LO   = 6;   // main set 18:6
  localparam int SET1_LO   = 19;  // alternate one 31:19
  localparam int SET2_LO   = 32;  // alternate two 44:32
  localparam int SET3_LO   = 45;  // alternate three 57:45
  localparam int RSV_LO    = 58;  // 63:58 reserved, read zero

  // field positions inside one status set
  localparam int SF_FTZ    = 0;
  localparam int SF_WRE    = 1;
  localparam int SF_PC_LO  = 2;   // 3:2
  localparam int SF_RC_LO  = 4;   // 5:4
  localparam int SF_TD     = 6;
  localparam int SF_FLG_LO = 7;   // 12:7

  // exception order, shared by trap-disable bits and sticky flags
  localparam int EX_INV = 0;
  localparam int EX_DEN = 1;
  localparam int EX_ZDV = 2;
  localparam int EX_OVF = 3;
  localparam int EX_UNF = 4;
  localparam int EX_INX = 5;

  // values after reset
  localparam logic [5:0]  TRAPS_RST = 6'h3f;
  localparam logic [12:0] SET_RST   = 13'h0000;

  // computation model figures
  localparam logic [6:0] PREC_SGL = 7'h18; // 24 bits
  localparam logic [6:0] PREC_DBL = 7'h35; // 53 bits
  localparam logic [6:0] PREC_EXT = 7'h40; // 64 bits
  localparam logic [4:0] EXP_SGL  = 5'h08; // 8 bits
  localparam logic [4:0] EXP_DBL  = 5'h0b; // 11 bits
  localparam logic [4:0] EXP_STK  = 5'h0f; // 15 bits
  localparam logic [4:0] EXP_REG  = 5'h11; // 17 bits

  // precision completer / instruction class of an operation
  typedef enum logic [2:0] {
    FPSC_CLS_SGL,       // single completer
    FPSC_CLS_DBL,       // double completer
    FPSC_CLS_NONE,      // no completer, dynamic precision
    FPSC_CLS_PAR,       // parallel, no completer
    FPSC_CLS_NONPAR     // non-parallel, no completer
  } fpsc_cls_t;

  // rounding direction
  typedef enum logic [1:0] {
    FPSC_RND_NEAR  = 2'b00,
    FPSC_RND_DOWN  = 2'b01,
    FPSC_RND_UP    = 2'b10,
    FPSC_RND_TRUNC = 2'b11
  } fpsc_rnd_t;

  // control query from an arithmetic unit
  typedef struct packed {
    logic      valid;
    logic [1:0] set_sel;
    fpsc_cls_t cls;
  } fpsc_query_t;

  // registered controls handed back
  typedef struct packed {
    logic       valid;
    fpsc_rnd_t  rnd;
    logic [6:0] prec_bits;
    logic [4:0] exp_bits;
    logic       reserved;  // reserved precision encoding chosen
    logic       ftz_now;   // flush applies (ftz set, underflow disabled)
    logic [5:0] disables;  // effective trap disables
  } fpsc_ctl_t;

  // exception report from an arithmetic unit at completion
  typedef struct packed {
    logic       valid;
    logic [1:0] set_sel;
    logic [5:0] exc;         // exceptions detected, denorm bit ignored
    logic       den_used;    // denormal/unnormal entered the calculation
    logic       nan_operand; // a nan operand was present
    logic       tiny;        // result detected tiny
  } fpsc_evt_t;

  // registered outcome of a report
  typedef struct packed {
    logic       fault;   // invalid, denorm or zero-divide fault
    logic       trap;    // overflow, underflow or inexact trap
    logic [5:0] cause;
    logic       flush;   // replace result by signed zero
  } fpsc_exc_t;

  // decoded computation model
  typedef struct packed {
    logic [6:0] prec_bits;
    logic [4:0] exp_bits;
    logic       reserved;
  } fpsc_model_t;

endpackage

// file: hw/fpsc_model_dec.sv
// computation model decoder: precision and exponent range from class, pc and wre
module fpsc_model_dec (
  input  wire fpsc_pkg::fpsc_cls_t   cls,
  input  wire logic [1:0]            pc,
  input  wire logic                  wre,
  output fpsc_pkg::fpsc_model_t      model
);

  // pure decode; the caller registers the result
  always_comb begin
    model = '0;
    unique case (cls)
      fpsc_pkg::FPSC_CLS_SGL: begin
        // completer fixes precision, pc ignored
        model.prec_bits = fpsc_pkg::PREC_SGL;
        model.exp_bits  = wre ? fpsc_pkg::EXP_REG : fpsc_pkg::EXP_SGL;
      end
      fpsc_pkg::FPSC_CLS_DBL: begin
        model.prec_bits = fpsc_pkg::PREC_DBL;
        model.exp_bits  = wre ? fpsc_pkg::EXP_REG : fpsc_pkg::EXP_DBL;
      end
      fpsc_pkg::FPSC_CLS_NONE: begin
        // dynamic precision from the set
        model.exp_bits = wre ? fpsc_pkg::EXP_REG : fpsc_pkg::EXP_STK;
        unique case (pc)
          2'b00: model.prec_bits = fpsc_pkg::PREC_SGL;
          2'b10: model.prec_bits = fpsc_pkg::PREC_DBL;
          2'b11: model.prec_bits = fpsc_pkg::PREC_EXT;
          2'b01: begin
            // reserved: no figures, flagged to the unit
            model.prec_bits = '0;
            model.exp_bits  = '0;
            model.reserved  = 1'b1;
          end
        endcase
      end
      fpsc_pkg::FPSC_CLS_PAR: begin
        // pair of singles, pc and wre ignored
        model.prec_bits = fpsc_pkg::PREC_SGL;
        model.exp_bits  = fpsc_pkg::EXP_SGL;
      end
      fpsc_pkg::FPSC_CLS_NONPAR: begin
        model.prec_bits = fpsc_pkg::PREC_EXT;
        model.exp_bits  = fpsc_pkg::EXP_REG;
      end
      default: begin
        // illegal class code: all zero, marked reserved
        model.reserved = 1'b1;
      end
    endcase
  end

endmodule // fpsc_model_dec

// file: hw/fpsc_top.sv
// fp status/control register bank with apb access and arithmetic-unit ports
//
// The address map and the APB interface to the registers are this design's own decisions.

// Notes on behaviour
// - one main set plus three alternate sets
// - traps, four sets, reserved top bits layout
// - bits 0..2 disable invalid, denorm, zdiv faults
// - bits 3..5 disable overflow, underflow, inexact traps
// - set fields: ftz, wre, pc, rc, override
// - set bits 12:7 are sticky exception flags
// - denorm flag only when used in calculation
// - only executing exceptions raise; writes never
// - flush tiny results to signed zero
// - enabled underflow wins; ftz then ignored
// - flush sets underflow, inexact; inexact may trap
// - rounding field selects one of four directions
// - single/double completer fixes precision; range too unless wre
// - no completer: pc picks precision, 01 reserved
// - parallel without completer: two singles
// - non-parallel without completer: 64/17 bits
// - override set treats all traps disabled
// - main set override reads zero always
module fpsc_top (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire fpsc_pkg::fpsc_query_t query,
  output fpsc_pkg::fpsc_ctl_t       ctl,
  input  wire fpsc_pkg::fpsc_evt_t  evt,
  output fpsc_pkg::fpsc_exc_t       exc
);

  // storage
  logic [5:0]  traps_reg;                    // global trap disables
  logic [12:0] set_reg [fpsc_pkg::SET_NUM];  // four status sets
  logic [31:0] prdata_reg;                   // read data
  logic        pready_reg;                   // one wait state then ready
  logic        pslverr_reg;                  // unmapped address answer
  fpsc_pkg::fpsc_ctl_t ctl_reg;              // registered control answer
  fpsc_pkg::fpsc_exc_t exc_reg;              // registered exception outcome

  // bus decode
  logic        hit_lo;        // address names the low word
  logic        hit_hi;        // address names the high word
  logic        mapped;        // either word
  logic        bus_done;      // completing access edge
  logic        wr_done;       // completing mapped write
  logic [63:0] img;           // current 64-bit view
  logic [63:0] img_wr;        // view after the pending write
  logic [63:0] lane_mask;     // bits touched by the write

  // event side
  logic [12:0] evt_set;       // the set the report addresses
  logic [5:0]  evt_off;       // effective disables of that set
  logic        evt_flush;     // result flushed to zero
  logic [5:0]  evt_flags;     // flags the report records
  logic [5:0]  evt_raise;     // enabled exceptions that interrupt

  // query side
  logic [12:0]             q_set;    // the set the query addresses
  fpsc_pkg::fpsc_model_t   q_model;  // decoded computation model

  // ---------------------------------------------------------------
  // register image
  // ---------------------------------------------------------------

  // assemble the 64-bit view; reserved bits and main override read zero
  always_comb begin
    img = '0;
    img[fpsc_pkg::TRAPS_LO +: fpsc_pkg::TRAPS_W] = traps_reg;
    img[fpsc_pkg::SET0_LO +: fpsc_pkg::SET_W]    = set_reg[0];
    img[fpsc_pkg::SET1_LO +: fpsc_pkg::SET_W]    = set_reg[1];
    img[fpsc_pkg::SET2_LO +: fpsc_pkg::SET_W]    = set_reg[2];
    img[fpsc_pkg::SET3_LO +: fpsc_pkg::SET_W]    = set_reg[3];
    // main override is never stored as one, so it already reads zero
    img[63:fpsc_pkg::RSV_LO] = '0;
  end

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------

  // address decode on aligned words only
  assign hit_lo   = (paddr == fpsc_pkg::ADDR_LO);
  assign hit_hi   = (paddr == fpsc_pkg::ADDR_HI);
  assign mapped   = hit_lo | hit_hi;
  // the access completes on the edge where our ready is seen high
  assign bus_done = psel & penable & pready_reg;
  assign wr_done  = bus_done & pwrite & mapped;

  // byte lanes of the write mapped onto the 64-bit view
  always_comb begin
    lane_mask = '0;
    for (int b = 0; b < 4; b++) begin
      if (pstrb[b]) begin
        if (hit_lo) begin
          lane_mask[b*8 +: 8] = 8'hff;
        end else if (hit_hi) begin
          lane_mask[32 + b*8 +: 8] = 8'hff;
        end
      end
    end
  end

  // merged view after the write; unwritten bytes keep their value
  assign img_wr = (img & ~lane_mask) | ({pwdata, pwdata} & lane_mask);

  // ready handshake: first access cycle waits, second completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else if (psel && penable && !pready_reg) begin
      pready_reg <= 1'b1;
    end else begin
      // drop right after completion so back-to-back transfers wait again
      pready_reg <= 1'b0;
    end
  end

  // read data and error are latched while ready rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else if (psel && penable && !pready_reg) begin
      pslverr_reg <= !mapped;
      if (pwrite || !mapped) begin
        // writes and unmapped reads return zero
        prdata_reg <= '0;
      end else if (hit_lo) begin
        prdata_reg <= img[31:0];
      end else begin
        prdata_reg <= img[63:32];
      end
    end else begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // global trap disables
  // ---------------------------------------------------------------

  // software only; hardware never changes them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      traps_reg <= fpsc_pkg::TRAPS_RST;
    end else if (wr_done) begin
      traps_reg <= img_wr[fpsc_pkg::TRAPS_LO +: fpsc_pkg::TRAPS_W];
    end
  end

  // ---------------------------------------------------------------
  // event decode for the addressed set
  // ---------------------------------------------------------------

  // the report selects its set by the two-bit selector
  assign evt_set = set_reg[evt.set_sel];

  // effective disables: override forces all six off
  assign evt_off = evt_set[fpsc_pkg::SF_TD] ? 6'h3f : traps_reg;

  always_comb begin
    evt_flags = evt.exc;
    // denorm flag only when the operand really entered the arithmetic
    evt_flags[fpsc_pkg::EX_DEN] = evt.den_used & ~evt.nan_operand;
    // flush needs ftz and a disabled underflow; enabled underflow wins
    evt_flush = evt.tiny & evt_set[fpsc_pkg::SF_FTZ]
                & evt_off[fpsc_pkg::EX_UNF];
    if (evt_flush) begin
      evt_flags[fpsc_pkg::EX_UNF] = 1'b1;
      evt_flags[fpsc_pkg::EX_INX] = 1'b1;
    end
    // only enabled exceptions of an executing operation interrupt
    evt_raise = evt.valid ? (evt_flags & ~evt_off) : 6'h00;
  end

  // ---------------------------------------------------------------
  // status sets, one per generate entry
  // ---------------------------------------------------------------

  // a hardware flag set in the same cycle as a software write wins
  for (genvar g = 0; g < fpsc_pkg::SET_NUM; g++) begin : g_set
    localparam int LO = (g == 0) ? fpsc_pkg::SET0_LO :
                        (g == 1) ? fpsc_pkg::SET1_LO :
                        (g == 2) ? fpsc_pkg::SET2_LO : fpsc_pkg::SET3_LO;
    logic [12:0] set_next;  // after write and event merge
    logic        hit_evt;   // report addresses this set

    assign hit_evt = evt.valid && (evt.set_sel == 2'(g));

    always_comb begin
      set_next = set_reg[g];
      if (wr_done) begin
        // software may write controls and flags; no interruption follows
        set_next = img_wr[LO +: fpsc_pkg::SET_W];
      end
      if (hit_evt) begin
        // sticky: events only ever add flags
        set_next[fpsc_pkg::SF_FLG_LO +: 6] =
          set_next[fpsc_pkg::SF_FLG_LO +: 6] | evt_flags;
      end
      if (g == 0) begin
        // main set has no override
        set_next[fpsc_pkg::SF_TD] = 1'b0;
      end
    end

    // one register per set
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        set_reg[g] <= fpsc_pkg::SET_RST;
      end else begin
        set_reg[g] <= set_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // exception outcome
  // ---------------------------------------------------------------

  // faults stop the operation, so a fault hides any trap of the same report
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_reg <= '0;
    end else if (evt.valid) begin
      exc_reg.fault <= |evt_raise[fpsc_pkg::EX_ZDV:fpsc_pkg::EX_INV];
      exc_reg.trap  <= ~|evt_raise[fpsc_pkg::EX_ZDV:fpsc_pkg::EX_INV]
                       & |evt_raise[fpsc_pkg::EX_INX:fpsc_pkg::EX_OVF];
      exc_reg.cause <= evt_raise;
      exc_reg.flush <= evt_flush;
    end else begin
      // outcome is a one-cycle pulse
      exc_reg <= '0;
    end
  end

  // ---------------------------------------------------------------
  // control query
  // ---------------------------------------------------------------

  // the query selects its set by the same selector
  assign q_set = set_reg[query.set_sel];

  // computation model decode kept in its own module
  fpsc_model_dec u_model (
    .cls   (query.cls),
    .pc    (q_set[fpsc_pkg::SF_PC_LO +: 2]),
    .wre   (q_set[fpsc_pkg::SF_WRE]),
    .model (q_model)
  );

  // answer one cycle after the query; controls seen before any same-cycle write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg <= '0;
    end else if (query.valid) begin
      ctl_reg.valid     <= 1'b1;
      ctl_reg.rnd       <= fpsc_pkg::fpsc_rnd_t'(q_set[fpsc_pkg::SF_RC_LO +: 2]);
      ctl_reg.prec_bits <= q_model.prec_bits;
      ctl_reg.exp_bits  <= q_model.exp_bits;
      ctl_reg.reserved  <= q_model.reserved;
      // ftz only effective when underflow is disabled
      ctl_reg.ftz_now   <= q_set[fpsc_pkg::SF_FTZ]
                           & (q_set[fpsc_pkg::SF_TD] | traps_reg[fpsc_pkg::EX_UNF]);
      ctl_reg.disables  <= q_set[fpsc_pkg::SF_TD] ? 6'h3f : traps_reg;
    end else begin
      ctl_reg <= '0;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign ctl     = ctl_reg;
  assign exc     = exc_reg;

endmodule // fpsc_top

// file: testbench/fpsc_checker_assertions.sv
// checker: port-level properties of the fp status/control block
module fpsc_checker (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic [11:0]           paddr,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           pwdata,
  input wire logic [3:0]            pstrb,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire fpsc_pkg::fpsc_query_t query,
  input wire fpsc_pkg::fpsc_ctl_t   ctl,
  input wire fpsc_pkg::fpsc_evt_t   evt,
  input wire fpsc_pkg::fpsc_exc_t   exc
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // decoded word addresses; anything else must be refused
  wire logic mapped = (paddr == fpsc_pkg::ADDR_LO) || (paddr == fpsc_pkg::ADDR_HI);

  // access phase still waiting for its answer
  sequence acc_wait_s;
    psel && penable && !pready;
  endsequence
  // read answer on the low or high word
  sequence rd_lo_s;
    pready && !pwrite && paddr == fpsc_pkg::ADDR_LO;
  endsequence
  sequence rd_hi_s;
    pready && !pwrite && paddr == fpsc_pkg::ADDR_HI;
  endsequence

  one_wait_a: assert property (acc_wait_s |=> pready ##1 !pready)
    else $error("apb answer not after exactly one wait");
  err_decode_a: assert property (pready |-> pslverr == !mapped)
    else $error("slave error does not match address decode");
  main_td_zero_a: assert property (rd_lo_s |-> !prdata[12])
    else $error("main set override read back nonzero");
  rsv_zero_a: assert property (rd_hi_s |-> prdata[31:26] == 6'h00)
    else $error("reserved top bits read back nonzero");
  ctl_answer_a: assert property (query.valid |=> ctl.valid
    ##1 (ctl.valid == $past(query.valid)))
    else $error("control answer missing");
  single_fixed_a: assert property (query.valid && query.cls == fpsc_pkg::FPSC_CLS_SGL
    |=> ctl.prec_bits == fpsc_pkg::PREC_SGL && !ctl.reserved)
    else $error("single completer precision wrong");
  par_model_a: assert property (query.valid && query.cls == fpsc_pkg::FPSC_CLS_PAR
    |=> ctl.prec_bits == fpsc_pkg::PREC_SGL && ctl.exp_bits == fpsc_pkg::EXP_SGL)
    else $error("parallel model wrong");
  nonpar_model_a: assert property (query.valid && query.cls == fpsc_pkg::FPSC_CLS_NONPAR
    |=> ctl.prec_bits == fpsc_pkg::PREC_EXT && ctl.exp_bits == fpsc_pkg::EXP_REG)
    else $error("non-parallel model wrong");
  ftz_gate_a: assert property (ctl.ftz_now |-> ctl.disables[fpsc_pkg::EX_UNF])
    else $error("flush offered while underflow enabled");
  no_evt_quiet_a: assert property (!evt.valid |=> !exc.fault && !exc.trap)
    else $error("interruption without a report");
  fault_first_a: assert property (exc.fault |-> !exc.trap && exc.cause[2:0] != 3'h0)
    else $error("fault without fault cause");
  trap_cause_a: assert property (exc.trap |-> exc.cause[2:0] == 3'h0
    && exc.cause[5:3] != 3'h0)
    else $error("trap cause wrong");
  flush_src_a: assert property (exc.flush |-> $past(evt.valid) && $past(evt.tiny))
    else $error("flush without tiny result");
endmodule // fpsc_checker

bind fpsc_top fpsc_checker u_fpsc_checker (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .query(query), .ctl(ctl),
  .evt(evt), .exc(exc));

// file: testbench/fpsc_fpu_model.sv
// far-side model: an arithmetic unit issuing control queries and exception reports
module fpsc_fpu_model (
  input  wire logic                pclk,
  output fpsc_pkg::fpsc_query_t    query,
  output fpsc_pkg::fpsc_evt_t      evt,
  input  wire fpsc_pkg::fpsc_ctl_t ctl,
  input  wire fpsc_pkg::fpsc_exc_t exc
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle until the bench asks for traffic
  initial begin
    query = '0;
    evt = '0;
  end

  // one query held for one edge; answer read mid-cycle so no edge race
  task automatic ask(input logic [1:0] sel, input fpsc_pkg::fpsc_cls_t cls,
                     output fpsc_pkg::fpsc_ctl_t c);
    @(posedge pclk);
    query <= '{valid: 1'b1, set_sel: sel, cls: cls};
    @(posedge pclk);
    query <= '0;
    @(negedge pclk);
    c = ctl;
  endtask

  // one completion report; den_used passed as the operand check found it
  task automatic report(input logic [1:0] sel, input logic [5:0] x, input logic du,
                        input logic nan, input logic tiny, output fpsc_pkg::fpsc_exc_t e);
    @(posedge pclk);
    evt <= {1'b1, sel, x, du, nan, tiny};
    @(posedge pclk);
    evt <= '0;
    @(negedge pclk);
    e = exc;
  endtask
endmodule // fpsc_fpu_model

// file: testbench/tb_fp_status_control_register.sv
// self-checking bench: apb register access plus query/report traffic
module tb_fp_status_control_register;
  timeunit 1ns;
  timeprecision 1ns;

  logic                  pclk;
  logic                  presetn;
  logic [11:0]           paddr;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [31:0]           pwdata;
  logic [3:0]            pstrb;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  fpsc_pkg::fpsc_query_t query;
  fpsc_pkg::fpsc_ctl_t   ctl;
  fpsc_pkg::fpsc_evt_t   evt;
  fpsc_pkg::fpsc_exc_t   exc;
  int                    err_count = 0;
  int                    comparisons = 0;
  int                    cycles = 0;

  fpsc_top u_fpsc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .query(query), .ctl(ctl), .evt(evt), .exc(exc));
  fpsc_fpu_model u_fpsc_fpu_model (.pclk(pclk), .query(query), .evt(evt), .ctl(ctl),
    .exc(exc));

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // hang guard, far above the few hundred cycles needed
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // compare, counting every check
  task automatic chk(input string what, input logic [63:0] ex, input logic [63:0] got);
    comparisons++;
    if (got !== ex) begin
      $display("CHECK FAILED %s expected %h seen %h", what, ex, got);
      err_count++;
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read one word and compare, error flag included
  task automatic rd(input logic [11:0] a, input logic [31:0] ex, input string what);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, 4'hf, r, e);
    chk(what, {1'b0, ex}, {e, r});
  endtask

  // write the whole 64-bit register from traps and four sets
  task automatic put(input logic [5:0] t, input logic [12:0] s0, input logic [12:0] s1,
                     input logic [12:0] s2, input logic [12:0] s3);
    logic [63:0] v;
    logic [31:0] r;
    logic        e;
    v = {6'h00, s3, s2, s1, s0, t};
    apb(1'b1, fpsc_pkg::ADDR_LO, v[31:0], 4'hf, r, e);
    apb(1'b1, fpsc_pkg::ADDR_HI, v[63:32], 4'hf, r, e);
  endtask

  // expected {precision, range, reserved} for class k
  function automatic logic [12:0] em(int k, logic [1:0] pc, logic w);
    case (k)
      0: em = {7'h18, w ? 5'h11 : 5'h08, 1'b0};
      1: em = {7'h35, w ? 5'h11 : 5'h0b, 1'b0};
      2: em = (pc == 2'b01) ? 13'h0001 :
              {pc == 2'b00 ? 7'h18 : pc == 2'b10 ? 7'h35 : 7'h40, w ? 5'h11 : 5'h0f, 1'b0};
      3: em = {7'h18, 5'h08, 1'b0};
      default: em = {7'h40, 5'h11, 1'b0};
    endcase
  endfunction

  // main sequence
  initial begin
    fpsc_pkg::fpsc_ctl_t c;
    fpsc_pkg::fpsc_exc_t x;
    logic [31:0]         r;
    logic                e;
    presetn = 1'b0;
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(fpsc_pkg::ADDR_LO, 32'h0000003f, "reset_lo");
    rd(fpsc_pkg::ADDR_HI, 32'h00000000, "reset_hi");
    // all ones: main override and top bits must stay zero
    apb(1'b1, fpsc_pkg::ADDR_LO, 32'hffffffff, 4'hf, r, e);
    rd(fpsc_pkg::ADDR_LO, 32'hffffefff, "ones_lo");
    apb(1'b1, fpsc_pkg::ADDR_HI, 32'hffffffff, 4'hf, r, e);
    rd(fpsc_pkg::ADDR_HI, 32'h03ffffff, "ones_hi");
    apb(1'b1, fpsc_pkg::ADDR_HI, 32'h00000000, 4'h1, r, e);
    rd(fpsc_pkg::ADDR_HI, 32'h03ffff00, "strobe_hi");
    apb(1'b0, 12'h008, 32'h0, 4'hf, r, e);
    chk("unmapped", 33'h100000000, {e, r});
    // every class, precision and range code; rounding field follows pc
    for (int i = 0; i < 40; i++) begin
      put(6'h3f, 13'h0, {7'h00, i[2:1], i[2:1], i[0], 1'b0}, 13'h0, 13'h0);
      u_fpsc_fpu_model.ask(2'd1, fpsc_pkg::fpsc_cls_t'(i / 8), c);
      chk("model", {1'b1, i[2:1], em(i / 8, i[2:1], i[0]), 1'b0, 6'h3f}, c);
    end
    // override per set; main set override cannot be set
    put(6'h05, 13'h0040, 13'h0001, 13'h0041, 13'h0000);
    u_fpsc_fpu_model.ask(2'd0, fpsc_pkg::FPSC_CLS_NONPAR, c);
    chk("main_dis", {1'b1, 2'b00, 13'h1022, 1'b0, 6'h05}, c);
    u_fpsc_fpu_model.ask(2'd1, fpsc_pkg::FPSC_CLS_NONPAR, c);
    chk("alt1_dis", {1'b1, 2'b00, 13'h1022, 1'b0, 6'h05}, c);
    u_fpsc_fpu_model.ask(2'd2, fpsc_pkg::FPSC_CLS_NONPAR, c);
    chk("alt2_dis", {1'b1, 2'b00, 13'h1022, 1'b1, 6'h3f}, c);
    // reports into set two, all exceptions enabled
    put(6'h00, 13'h0, 13'h0, 13'h0, 13'h0);
    u_fpsc_fpu_model.report(2'd2, 6'h20, 1'b0, 1'b0, 1'b0, x);
    chk("inexact", 9'h0c0, x);
    u_fpsc_fpu_model.report(2'd2, 6'h21, 1'b0, 1'b0, 1'b0, x);
    chk("invalid", 9'h142, x);
    u_fpsc_fpu_model.report(2'd2, 6'h00, 1'b1, 1'b1, 1'b0, x);
    chk("den_nan", 9'h000, x);
    rd(fpsc_pkg::ADDR_HI, 32'h00001080, "sticky");
    u_fpsc_fpu_model.report(2'd2, 6'h00, 1'b1, 1'b0, 1'b0, x);
    chk("den_used", 9'h104, x);
    rd(fpsc_pkg::ADDR_HI, 32'h00001180, "den_flag");
    // flush with underflow disabled, then ignored with it enabled
    put(6'h10, 13'h0, 13'h0, 13'h0001, 13'h0);
    u_fpsc_fpu_model.report(2'd2, 6'h00, 1'b0, 1'b0, 1'b1, x);
    chk("flush", 9'h0c1, x);
    rd(fpsc_pkg::ADDR_HI, 32'h00001801, "flush_flags");
    put(6'h00, 13'h0, 13'h0, 13'h0001, 13'h0);
    u_fpsc_fpu_model.report(2'd2, 6'h10, 1'b0, 1'b0, 1'b1, x);
    chk("no_flush", 9'h0a0, x);
    // software setting flags raises nothing
    put(6'h00, 13'h1f80, 13'h1f80, 13'h1f80, 13'h1f80);
    @(negedge pclk);
    chk("sw_flags", 9'h000, exc);
    tally_and_finish();
  end
endmodule // tb_fp_status_control_register
